// ===== hdl/enc_fault_pkg.sv
// constants for the encoder link fault monitor
// assumes a single 125 MHz drive clock and a 32-bit wishbone register bus
package enc_fault_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int START_TMO_MS = 50;
	localparam int START_TMO_CYC = START_TMO_MS * 1000 * CLK_MHZ;
	localparam int XFER_TMO_US = 100;
	localparam int XFER_TMO_CYC = XFER_TMO_US * CLK_MHZ;
	localparam int MONO_US = 20;
	localparam int MONO_CYC = MONO_US * CLK_MHZ;
	localparam int TMR_W = 23;

	// ------------------------------------------------------------
	// frame checking
	// ------------------------------------------------------------
	localparam int MAX_FRAME_BITS = 64;
	localparam int CNT_W = 7;
	localparam int CRC_W = 5;
	localparam logic [4:0] CRC_POLY = 5'h0B;

	// ------------------------------------------------------------
	// serial error word bit positions
	// ------------------------------------------------------------
	localparam int SE_ALARM = 0;
	localparam int SE_IDLE_LVL = 1;
	localparam int SE_NO_START = 2;
	localparam int SE_CRC = 3;
	localparam int SE_ACK = 4;
	localparam int SE_MODE = 5;
	localparam int SE_TMO_CYC = 6;
	localparam int SE_TMO_REG = 7;
	localparam int SE_TOO_LONG = 8;
	localparam int SE_OVERFLOW = 9;
	localparam int SE_REREAD = 10;
	localparam int SE_PARITY = 11;
	localparam int SE_MONO_LVL = 12;
	localparam int SE_LINE = 13;
	localparam int SE_REG_COMM = 14;
	localparam int SE_INTERNAL = 15;

	// ------------------------------------------------------------
	// amplitude scaling and thresholds
	// ------------------------------------------------------------
	localparam int STD_FULL_MV = 500;
	localparam int STD_FULL_CODE = 32'h0000_5333;
	localparam int RES_FULL_MV = 2900;
	localparam int RES_FULL_CODE = 32'h0000_6666;
	localparam int LOW_MV = 170;
	localparam int LOW_HF_MV = 120;
	localparam int RES_LOW_MV = 1070;
	localparam int RECT_MV = 130;
	localparam logic [15:0] LOW_CODE =
		16'(LOW_MV * STD_FULL_CODE / STD_FULL_MV);
	localparam logic [15:0] LOW_HF_CODE =
		16'(LOW_HF_MV * STD_FULL_CODE / STD_FULL_MV);
	localparam logic [15:0] RES_LOW_CODE =
		16'(RES_LOW_MV * RES_FULL_CODE / RES_FULL_MV);
	localparam logic [15:0] RECT_CODE =
		16'(RECT_MV * STD_FULL_CODE / STD_FULL_MV);
	localparam logic [32:0] LOW_SQ = 33'(LOW_CODE) * 33'(LOW_CODE);
	localparam logic [32:0] LOW_HF_SQ = 33'(LOW_HF_CODE) * 33'(LOW_HF_CODE);
	localparam logic [32:0] RES_LOW_SQ =
		33'(RES_LOW_CODE) * 33'(RES_LOW_CODE);

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SER_ERR = 8'h04;
	localparam logic [7:0] OFS_ENC_VALUE = 8'h08;
	localparam logic [7:0] OFS_AMP_LOW = 8'h0C;
	localparam logic [7:0] OFS_AMP_RECT = 8'h10;
	localparam logic [7:0] OFS_FAULTS = 8'h14;
	localparam int CTRL_DETAIL = 0;
	localparam int CTRL_RESOLVER = 1;
	localparam int CTRL_PI_ACK = 2;
	localparam int CTRL_INST_ACK = 3;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [31:0] ENC_OPAQUE_VALUE = 32'h0000_0001;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT_START,
		ST_IN_FRAME,
		ST_MONOFLOP
	} link_state_t;

endpackage : enc_fault_pkg

// ===== hdl/encoder_link_fault_monitor.sv
// fault detection and fault words for the serial position encoder channel
// assumes synchronous link strobes from the receiver, classic wishbone
//
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/100ps
module encoder_link_fault_monitor #(
	parameter int unsigned START_TMO_CYCLES = enc_fault_pkg::START_TMO_CYC,
	parameter int unsigned XFER_TMO_CYCLES = enc_fault_pkg::XFER_TMO_CYC
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// wishbone slave
	input wire logic [7:0] ADR_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	input wire logic WE_I,
	input wire logic [3:0] SEL_I,
	input wire logic STB_I,
	input wire logic CYC_I,
	output logic ACK_O,
	// link receiver
	input wire logic REQ_SENT,
	input wire logic REQ_IS_REG,
	input wire logic DATA_LINE,
	input wire logic RX_BIT_VALID,
	input wire logic RX_BIT,
	input wire logic FRAME_END,
	input wire logic FRAME_ALARM,
	input wire logic FRAME_ERR_BIT,
	// link events
	input wire logic ACK_ERR,
	input wire logic MODE_ERR,
	input wire logic OVERFLOW,
	input wire logic REREAD_MISMATCH,
	input wire logic PARITY_ERR,
	input wire logic LINE_ERR,
	input wire logic REG_COMM_ERR,
	input wire logic INTERNAL_ERR,
	// encoder error word
	input wire logic [15:0] ENC_CAUSE,
	input wire logic [15:0] ENC_SUPP,
	// track amplitudes
	input wire logic AMP_VALID,
	input wire logic signed [15:0] AMP_A,
	input wire logic signed [15:0] AMP_B,
	input wire logic HIGH_FREQ,
	// drive side
	input wire logic PULSE_INHIBIT,
	output logic SER_FAULT,
	output logic ENC_FAULT,
	output logic AMP_LOW_FAULT,
	output logic AMP_RECT_FAULT,
	output logic RAMP_STOP_REACTION
);
	enc_fault_pkg::link_state_t state_q;
	logic [enc_fault_pkg::TMR_W-1:0] tmr_q;
	logic [1:0] ctrl_q;
	logic [15:0] ser_err_q, ser_err_d, ser_set;
	logic [31:0] enc_val_q, amp_low_val_q, amp_rect_val_q, sq_a, sq_b;
	logic [32:0] mag_sq, thr_sq;
	logic [16:0] abs_a, abs_b;
	logic req_reg_q, enc_fault_q, amp_low_q, amp_rect_q;
	logic wb_req, wr_ctrl, pi_ack, inst_ack, crc_bad, too_long;
	logic in_frame, start_seen, frame_done, start_tmo, xfer_tmo, mono_done;
	logic enc_hit, amp_low_hit, rect_hit;

	// ------------------------------------------------------------
	// wishbone access
	// ------------------------------------------------------------
	assign wb_req = CYC_I && STB_I && !ACK_O;
	assign wr_ctrl = wb_req && WE_I && SEL_I[0] &&
		ADR_I == enc_fault_pkg::OFS_CTRL;
	assign pi_ack = wr_ctrl && DAT_I[enc_fault_pkg::CTRL_PI_ACK] &&
		PULSE_INHIBIT;
	assign inst_ack = wr_ctrl && DAT_I[enc_fault_pkg::CTRL_INST_ACK];

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ACK_O <= 1'b0;
		end else begin
			ACK_O <= wb_req;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ctrl_q <= enc_fault_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= DAT_I[1:0];
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			DAT_O <= 32'h0000_0000;
		end else if (wb_req && !WE_I) begin
			case (ADR_I)
				enc_fault_pkg::OFS_CTRL: DAT_O <= {30'h0000_0000, ctrl_q};
				enc_fault_pkg::OFS_SER_ERR: DAT_O <= {16'h0000, ser_err_q};
				enc_fault_pkg::OFS_ENC_VALUE: DAT_O <= enc_val_q;
				enc_fault_pkg::OFS_AMP_LOW: DAT_O <= amp_low_val_q;
				enc_fault_pkg::OFS_AMP_RECT: DAT_O <= amp_rect_val_q;
				enc_fault_pkg::OFS_FAULTS: DAT_O <= {28'h000_0000, amp_rect_q,
					amp_low_q, enc_fault_q, SER_FAULT};
				default: DAT_O <= 32'h0000_0000;
			endcase
		end else begin
			DAT_O <= 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------
	// link transfer supervision
	// ------------------------------------------------------------
	assign in_frame = state_q == enc_fault_pkg::ST_IN_FRAME;
	assign start_seen = state_q == enc_fault_pkg::ST_WAIT_START &&
		RX_BIT_VALID && RX_BIT;
	assign frame_done = in_frame && FRAME_END;
	assign start_tmo = state_q == enc_fault_pkg::ST_WAIT_START &&
		!start_seen && tmr_q == enc_fault_pkg::TMR_W'(START_TMO_CYCLES - 1);
	assign xfer_tmo = in_frame && !FRAME_END &&
		tmr_q == enc_fault_pkg::TMR_W'(XFER_TMO_CYCLES - 1);
	assign mono_done = state_q == enc_fault_pkg::ST_MONOFLOP &&
		tmr_q == enc_fault_pkg::TMR_W'(enc_fault_pkg::MONO_CYC - 1);

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			state_q <= enc_fault_pkg::ST_IDLE;
		end else begin
			case (state_q)
				enc_fault_pkg::ST_IDLE: begin
					if (REQ_SENT) begin
						state_q <= enc_fault_pkg::ST_WAIT_START;
					end
				end
				enc_fault_pkg::ST_WAIT_START: begin
					if (start_seen) begin
						state_q <= enc_fault_pkg::ST_IN_FRAME;
					end else if (start_tmo) begin
						state_q <= enc_fault_pkg::ST_IDLE;
					end
				end
				enc_fault_pkg::ST_IN_FRAME: begin
					if (FRAME_END) begin
						state_q <= enc_fault_pkg::ST_MONOFLOP;
					end else if (xfer_tmo) begin
						state_q <= enc_fault_pkg::ST_IDLE;
					end
				end
				enc_fault_pkg::ST_MONOFLOP: begin
					if (mono_done) begin
						state_q <= enc_fault_pkg::ST_IDLE;
					end
				end
				default: state_q <= enc_fault_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST || state_q == enc_fault_pkg::ST_IDLE || start_seen ||
			frame_done) begin
			tmr_q <= '0;
		end else begin
			tmr_q <= tmr_q + 1'b1;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			req_reg_q <= 1'b0;
		end else if (state_q == enc_fault_pkg::ST_IDLE && REQ_SENT) begin
			req_reg_q <= REQ_IS_REG;
		end
	end

	frame_checker u_checker (
		.clk(REF_CLK),
		.rst(RST),
		.clear(start_seen),
		.bit_valid(in_frame && RX_BIT_VALID),
		.bit_in(RX_BIT),
		.frame_end(frame_done),
		.crc_bad(crc_bad),
		.too_long(too_long)
	);

	// ------------------------------------------------------------
	// serial error word
	// ------------------------------------------------------------
	always_comb begin
		ser_set = 16'h0000;
		ser_set[enc_fault_pkg::SE_ALARM] = frame_done && FRAME_ALARM;
		ser_set[enc_fault_pkg::SE_IDLE_LVL] =
			state_q == enc_fault_pkg::ST_IDLE && !DATA_LINE;
		ser_set[enc_fault_pkg::SE_NO_START] = start_tmo;
		ser_set[enc_fault_pkg::SE_CRC] = crc_bad;
		ser_set[enc_fault_pkg::SE_ACK] = ACK_ERR;
		ser_set[enc_fault_pkg::SE_MODE] = MODE_ERR;
		ser_set[enc_fault_pkg::SE_TMO_CYC] = xfer_tmo && !req_reg_q;
		ser_set[enc_fault_pkg::SE_TMO_REG] = xfer_tmo && req_reg_q;
		ser_set[enc_fault_pkg::SE_TOO_LONG] = too_long;
		ser_set[enc_fault_pkg::SE_OVERFLOW] = OVERFLOW;
		ser_set[enc_fault_pkg::SE_REREAD] = REREAD_MISMATCH;
		ser_set[enc_fault_pkg::SE_PARITY] = PARITY_ERR;
		ser_set[enc_fault_pkg::SE_MONO_LVL] =
			state_q == enc_fault_pkg::ST_MONOFLOP && DATA_LINE;
		ser_set[enc_fault_pkg::SE_LINE] = LINE_ERR;
		ser_set[enc_fault_pkg::SE_REG_COMM] = REG_COMM_ERR;
		ser_set[enc_fault_pkg::SE_INTERNAL] = INTERNAL_ERR;
	end

	assign ser_err_d = (pi_ack ? 16'h0000 : ser_err_q) | ser_set;

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ser_err_q <= 16'h0000;
			SER_FAULT <= 1'b0;
		end else begin
			ser_err_q <= ser_err_d;
			SER_FAULT <= ser_err_d != 16'h0000;
		end
	end

	// ------------------------------------------------------------
	// encoder internal error
	// ------------------------------------------------------------
	assign enc_hit = frame_done && FRAME_ERR_BIT;

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			enc_fault_q <= 1'b0;
			enc_val_q <= 32'h0000_0000;
		end else if (enc_hit && !enc_fault_q) begin
			enc_fault_q <= 1'b1;
			enc_val_q <= ctrl_q[enc_fault_pkg::CTRL_DETAIL] ?
				{ENC_SUPP, ENC_CAUSE} : enc_fault_pkg::ENC_OPAQUE_VALUE;
		end else if (pi_ack && !enc_hit) begin
			enc_fault_q <= 1'b0;
			enc_val_q <= 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------
	// track amplitude monitor
	// ------------------------------------------------------------
	assign sq_a = 32'(AMP_A) * 32'(AMP_A);
	assign sq_b = 32'(AMP_B) * 32'(AMP_B);
	assign mag_sq = {1'b0, sq_a} + {1'b0, sq_b};
	assign thr_sq = ctrl_q[enc_fault_pkg::CTRL_RESOLVER] ?
		enc_fault_pkg::RES_LOW_SQ :
		(HIGH_FREQ ? enc_fault_pkg::LOW_HF_SQ : enc_fault_pkg::LOW_SQ);
	assign amp_low_hit = AMP_VALID && mag_sq < thr_sq;
	assign abs_a = AMP_A[15] ? 17'h0_0000 - {1'b1, AMP_A} : {1'b0, AMP_A};
	assign abs_b = AMP_B[15] ? 17'h0_0000 - {1'b1, AMP_B} : {1'b0, AMP_B};
	assign rect_hit = AMP_VALID && abs_a < {1'b0, enc_fault_pkg::RECT_CODE} &&
		abs_b < {1'b0, enc_fault_pkg::RECT_CODE};

	// pack track b high, a low
	// value is the sample that tripped
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			amp_low_q <= 1'b0;
			amp_low_val_q <= 32'h0000_0000;
		end else if (amp_low_hit && !amp_low_q) begin
			amp_low_q <= 1'b1;
			amp_low_val_q <= {AMP_B, AMP_A};
		end else if (pi_ack && !amp_low_hit) begin
			amp_low_q <= 1'b0;
			amp_low_val_q <= 32'h0000_0000;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			amp_rect_q <= 1'b0;
			amp_rect_val_q <= 32'h0000_0000;
		end else if (rect_hit && !amp_rect_q) begin
			amp_rect_q <= 1'b1;
			amp_rect_val_q <= {AMP_B, AMP_A};
		end else if (inst_ack && !rect_hit) begin
			amp_rect_q <= 1'b0;
			amp_rect_val_q <= 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------
	// fault outputs
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ENC_FAULT <= 1'b0;
			AMP_LOW_FAULT <= 1'b0;
			AMP_RECT_FAULT <= 1'b0;
			RAMP_STOP_REACTION <= 1'b0;
		end else begin
			ENC_FAULT <= enc_fault_q;
			AMP_LOW_FAULT <= amp_low_q;
			AMP_RECT_FAULT <= amp_rect_q;
			RAMP_STOP_REACTION <= SER_FAULT || enc_fault_q || amp_low_q ||
				amp_rect_q;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_wb_ack_pulse: assert property (@(posedge REF_CLK) disable iff (RST)
		ACK_O |=> !ACK_O)
		else $error("ack held longer than one cycle");
	a_ramp_stop_fault: assert property (@(posedge REF_CLK)
		disable iff (RST) SER_FAULT |=> RAMP_STOP_REACTION)
		else $error("serial fault without ramp stop");
	a_fault_clear_ack: assert property (@(posedge REF_CLK)
		disable iff (RST) $fell(SER_FAULT) |-> $past(pi_ack))
		else $error("serial fault cleared without pulse inhibit ack");
	a_idle_level_flag: assert property (@(posedge REF_CLK)
		disable iff (RST) (state_q == enc_fault_pkg::ST_IDLE && !DATA_LINE)
		|=> ser_err_q[enc_fault_pkg::SE_IDLE_LVL])
		else $error("idle level error not flagged");
	a_start_timeout: assert property (@(posedge REF_CLK)
		disable iff (RST) start_tmo |=> ser_err_q[enc_fault_pkg::SE_NO_START] &&
		state_q == enc_fault_pkg::ST_IDLE)
		else $error("start bit timeout not flagged");
	a_crc_flag: assert property (@(posedge REF_CLK) disable iff (RST)
		frame_done ##1 crc_bad |=> ser_err_q[enc_fault_pkg::SE_CRC])
		else $error("crc mismatch not flagged");
	a_length_flag: assert property (@(posedge REF_CLK) disable iff (RST)
		too_long |=> ser_err_q[enc_fault_pkg::SE_TOO_LONG] && SER_FAULT)
		else $error("overlong frame not flagged");
	a_latch_hold: assert property (@(posedge REF_CLK) disable iff (RST)
		(ser_err_q[enc_fault_pkg::SE_ALARM] && !pi_ack)
		|=> ser_err_q[enc_fault_pkg::SE_ALARM])
		else $error("latched error bit lost without ack");
	a_amp_packing: assert property (@(posedge REF_CLK) disable iff (RST)
		(amp_low_hit && !amp_low_q)
		|=> amp_low_val_q == {$past(AMP_B), $past(AMP_A)} ##1 AMP_LOW_FAULT)
		else $error("amplitude value packed wrongly");
	a_rect_inst_ack: assert property (@(posedge REF_CLK)
		disable iff (RST)
		(inst_ack && !rect_hit) |=> !amp_rect_q ##1 !AMP_RECT_FAULT)
		else $error("rectified fault not cleared by instant ack");

endmodule : encoder_link_fault_monitor

// ===== hdl/frame_checker.sv
// bit counter and crc residue check for one received encoder frame
// assumes bits arrive msb first with the crc as the last bits
`timescale 1ns/100ps
module frame_checker (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// frame bits
	input wire logic clear,
	input wire logic bit_valid,
	input wire logic bit_in,
	input wire logic frame_end,
	// results
	output logic crc_bad,
	output logic too_long
);
	logic [4:0] crc_q;
	logic [enc_fault_pkg::CNT_W-1:0] cnt_q;
	logic long_seen_q;
	logic fb;

	assign fb = crc_q[4] ^ bit_in;

	// ------------------------------------------------------------
	// crc residue
	// ------------------------------------------------------------
	// recompute checksum
	always_ff @(posedge clk) begin
		if (rst || clear) begin
			crc_q <= 5'h00;
		end else if (bit_valid) begin
			crc_q <= {crc_q[3:0], 1'b0} ^ (fb ? enc_fault_pkg::CRC_POLY : 5'h00);
		end
	end

	// ------------------------------------------------------------
	// bit count
	// ------------------------------------------------------------
	// count frame bits
	always_ff @(posedge clk) begin
		if (rst || clear) begin
			cnt_q <= '0;
		end else if (bit_valid &&
			cnt_q != enc_fault_pkg::CNT_W'(enc_fault_pkg::MAX_FRAME_BITS)) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || clear) begin
			long_seen_q <= 1'b0;
			too_long <= 1'b0;
		end else begin
			too_long <= bit_valid && !long_seen_q &&
				cnt_q == enc_fault_pkg::CNT_W'(enc_fault_pkg::MAX_FRAME_BITS);
			if (too_long) begin
				long_seen_q <= 1'b1;
			end
		end
	end

	// residue or short frame is bad
	always_ff @(posedge clk) begin
		if (rst) begin
			crc_bad <= 1'b0;
		end else begin
			crc_bad <= frame_end && (crc_q != 5'h00 ||
				cnt_q <= enc_fault_pkg::CNT_W'(enc_fault_pkg::CRC_W));
		end
	end

endmodule : frame_checker

// ===== sim/encoder_model.sv
// encoder side of the serial link: requests, frames, line level
// assumes the monitor samples every strobe on the shared rising edge
`timescale 1ns/100ps
module encoder_model (
	// clock
	input wire logic clk,
	// link
	output logic req_sent,
	output logic req_is_reg,
	output logic data_line,
	output logic rx_bit_valid,
	output logic rx_bit,
	output logic frame_end,
	output logic frame_alarm,
	output logic frame_err_bit
);
	initial begin
		{req_sent, req_is_reg, rx_bit_valid, frame_end} = 4'h0;
		{frame_alarm, frame_err_bit, rx_bit} = 3'h0;
		data_line = 1'b1;
	end
	task automatic request();
		@(posedge clk);
		req_sent <= 1'b1;
		@(posedge clk);
		req_sent <= 1'b0;
	endtask : request
	// bit value inverted outside the strobe
	task automatic put_bit(input logic b);
		@(posedge clk);
		rx_bit_valid <= 1'b1;
		rx_bit <= b;
		@(posedge clk);
		rx_bit_valid <= 1'b0;
		rx_bit <= ~b;
	endtask : put_bit
	task automatic frame(input logic [63:0] d, input int n,
		input logic crc_ok, input logic alarm, input logic err_bit,
		input logic mono_high);
		logic [4:0] crc;
		logic fb;
		crc = 5'h00;
		request();
		put_bit(1'b1);
		for (int i = n - 1; i >= 0; i--) begin
			fb = crc[4] ^ d[i];
			crc = {crc[3:0], 1'b0} ^ (fb ? 5'h0B : 5'h00);
			put_bit(d[i]);
		end
		if (!crc_ok) begin
			crc = ~crc;
		end
		for (int i = 4; i >= 0; i--) begin
			put_bit(crc[i]);
		end
		@(posedge clk);
		frame_end <= 1'b1;
		frame_alarm <= alarm;
		frame_err_bit <= err_bit;
		data_line <= mono_high;
		@(posedge clk);
		frame_end <= 1'b0;
		frame_alarm <= 1'b0;
		frame_err_bit <= 1'b0;
		repeat (2500) @(posedge clk);
		data_line <= 1'b1;
	endtask : frame
	task automatic stall(input logic is_reg);
		req_is_reg <= is_reg;
		request();
		put_bit(1'b1);
		put_bit(1'b0);
		repeat (1010) @(posedge clk);
		req_is_reg <= 1'b0;
	endtask : stall
	task automatic line_low();
		@(posedge clk);
		data_line <= 1'b0;
		@(posedge clk);
		data_line <= 1'b1;
	endtask : line_low
endmodule : encoder_model

// ===== sim/tb_top.sv
// self-checking bench for the encoder link fault monitor
// assumes classic wishbone timing and the encoder model on the link
`timescale 1ns/100ps
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] dat_o;
	logic [31:0] exp;
	logic we = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic [3:0] sel = 4'h0;
	logic ack;
	logic [7:0] ev = 8'h00;
	logic [15:0] cause = 16'h0;
	logic [15:0] supp = 16'h0;
	logic amp_valid = 1'b0;
	logic pi = 1'b0;
	logic hf = 1'b0;
	logic signed [15:0] amp_a = 16'sh0;
	logic signed [15:0] amp_b = 16'sh0;
	logic req, req_reg, line, bv, bt, fe, fa, fb;
	logic ser_f, enc_f, low_f, rect_f, stop_f;
	int pos[8] = '{4, 5, 9, 10, 11, 13, 14, 15};
	int fail_count = 0;
	int samples_checked = 0;
	always #4 clk = ~clk;
	encoder_model i_encoder_model (.clk(clk), .req_sent(req),
		.req_is_reg(req_reg), .data_line(line), .rx_bit_valid(bv),
		.rx_bit(bt), .frame_end(fe), .frame_alarm(fa), .frame_err_bit(fb));
	encoder_link_fault_monitor #(.START_TMO_CYCLES(200),
		.XFER_TMO_CYCLES(1000)) i_encoder_link_fault_monitor (
		.REF_CLK(clk), .RST(rst), .ADR_I(adr), .DAT_I(wdat),
		.DAT_O(dat_o), .WE_I(we), .SEL_I(sel), .STB_I(stb), .CYC_I(cyc),
		.ACK_O(ack), .REQ_SENT(req), .REQ_IS_REG(req_reg),
		.DATA_LINE(line), .RX_BIT_VALID(bv), .RX_BIT(bt),
		.FRAME_END(fe), .FRAME_ALARM(fa), .FRAME_ERR_BIT(fb),
		.ACK_ERR(ev[0]), .MODE_ERR(ev[1]), .OVERFLOW(ev[2]),
		.REREAD_MISMATCH(ev[3]), .PARITY_ERR(ev[4]), .LINE_ERR(ev[5]),
		.REG_COMM_ERR(ev[6]), .INTERNAL_ERR(ev[7]), .ENC_CAUSE(cause),
		.ENC_SUPP(supp), .AMP_VALID(amp_valid), .AMP_A(amp_a),
		.AMP_B(amp_b), .HIGH_FREQ(hf), .PULSE_INHIBIT(pi),
		.SER_FAULT(ser_f), .ENC_FAULT(enc_f), .AMP_LOW_FAULT(low_f),
		.AMP_RECT_FAULT(rect_f), .RAMP_STOP_REACTION(stop_f));
	// ------------------------------------------------------------
	// bus and compare tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		samples_checked++;
		if (got !== want) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, want);
		end
	endtask : chk
	task automatic wb(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		we <= w;
		wdat <= d;
		sel <= 4'hF;
		cyc <= 1'b1;
		stb <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = dat_o;
		chk({31'h0, ack}, 32'h1);
		@(posedge clk);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] want);
		logic [31:0] q;
		wb(a, 1'b0, 32'h0, q);
		chk(q, want);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(a, 1'b1, d, q);
	endtask : wr
	task automatic pins(input logic [4:0] want);
		chk({27'h0, stop_f, rect_f, low_f, enc_f, ser_f}, {27'h0, want});
	endtask : pins
	task automatic amp(input logic signed [15:0] a,
		input logic signed [15:0] b);
		@(posedge clk);
		amp_valid <= 1'b1;
		amp_a <= a;
		amp_b <= b;
		@(posedge clk);
		amp_valid <= 1'b0;
	endtask : amp
	task automatic stop_test();
		$display("compares %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		#400000;
		fail_count++;
		stop_test();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd(8'h14, 32'h0);
		pins(5'h00);
		$display("test reset done");
		wr(8'h00, 32'h1);
		rd(8'h00, 32'h1);
		cause <= 16'h0040;
		supp <= 16'h0001;
		i_encoder_model.frame(64'h2D, 6, 1'b1, 1'b0, 1'b1, 1'b0);
		rd(8'h08, 32'h0001_0040);
		rd(8'h04, 32'h0);
		pins(5'h12);
		i_encoder_model.frame(64'h15, 5, 1'b0, 1'b1, 1'b0, 1'b0);
		rd(8'h04, 32'h9);
		rd(8'h14, 32'h3);
		i_encoder_model.frame(64'hFFFF_0000_1234_5678, 64, 1'b1, 1'b0,
			1'b0, 1'b0);
		rd(8'h04, 32'h109);
		$display("test frames done");
		i_encoder_model.request();
		repeat (205) @(posedge clk);
		rd(8'h04, 32'h10D);
		$display("test start timeout done");
		exp = 32'h10D;
		foreach (pos[i]) begin
			@(posedge clk);
			ev[i] <= 1'b1;
			@(posedge clk);
			ev[i] <= 1'b0;
			exp[pos[i]] = 1'b1;
			rd(8'h04, exp);
		end
		$display("test events done");
		i_encoder_model.stall(1'b0);
		exp[6] = 1'b1;
		rd(8'h04, exp);
		i_encoder_model.stall(1'b1);
		exp[7] = 1'b1;
		rd(8'h04, exp);
		i_encoder_model.frame(64'h2D, 6, 1'b1, 1'b0, 1'b0, 1'b1);
		exp[12] = 1'b1;
		rd(8'h04, exp);
		i_encoder_model.line_low();
		exp[1] = 1'b1;
		rd(8'h04, exp);
		rd(8'h04, 32'hFFFF);
		$display("test timeouts and line levels done");
		wr(8'h00, 32'h5);
		rd(8'h04, exp);
		pi <= 1'b1;
		wr(8'h00, 32'h5);
		rd(8'h04, 32'h0);
		rd(8'h08, 32'h0);
		pins(5'h00);
		pi <= 1'b0;
		$display("test acknowledge done");
		amp(enc_fault_pkg::LOW_CODE, 16'sh0);
		rd(8'h14, 32'h0);
		amp(16'sd100, -16'sd100);
		rd(8'h0C, 32'hFF9C_0064);
		rd(8'h10, 32'hFF9C_0064);
		rd(8'h14, 32'hC);
		pins(5'h1C);
		wr(8'h00, 32'h9);
		rd(8'h14, 32'h4);
		rd(8'h10, 32'h0);
		pi <= 1'b1;
		wr(8'h00, 32'h5);
		rd(8'h14, 32'h0);
		hf <= 1'b1;
		amp(enc_fault_pkg::LOW_CODE - 16'h0001, 16'sh0);
		rd(8'h14, 32'h0);
		amp(enc_fault_pkg::LOW_HF_CODE - 16'h0001, 16'sh0);
		rd(8'h14, 32'hC);
		hf <= 1'b0;
		wr(8'h00, 32'hE);
		rd(8'h14, 32'h0);
		amp(enc_fault_pkg::RES_LOW_CODE, 16'sh0);
		rd(8'h14, 32'h0);
		amp(enc_fault_pkg::RES_LOW_CODE - 16'h0001, 16'sh0);
		rd(8'h14, 32'h4);
		rd(8'h0C, {16'h0000, enc_fault_pkg::RES_LOW_CODE - 16'h0001});
		$display("test amplitude done");
		i_encoder_model.frame(64'h2D, 6, 1'b1, 1'b0, 1'b1, 1'b0);
		rd(8'h08, enc_fault_pkg::ENC_OPAQUE_VALUE);
		pi <= 1'b0;
		$display("test opaque value done");
		stop_test();
	end
endmodule : tb_top
